/* bfw_cmd.sv */
/*
 * Host command decoder for brightness, backlight and compressed fill writes.
 * Assumes host pins are asynchronous to clk and held stable for at least
 * three clock periods around each strobe edge; sleep_in and sw_reset come
 * from controller logic on clk.
 */
// Functional notes
// - Brightness read returns a dummy byte, then the stored brightness.
// - Brightness code is monotonic: zero lowest, all ones highest.
// - Stored brightness is cleared while sleep is in effect.
// - Brightness read gives zero when the control bit is zero.
// - With the control bit set, brightness read gives the manual value.
// - Display control write takes one byte; bit 2 is backlight on.
// - Backlight off forces backlight outputs low; on enables them.
// - Display control read returns dummy, then backlight bit at bit 2.
// - Deep colour words: red 7:2, green 15:10, blue 23:18.
// - Deep colour count is bits 31:24 plus one, fill on that byte.
// - Shallow colour: red 7:3, blue 12:8, green from 2:0 and 15:13.
// - Shallow colour count is bits 23:16 plus one; top byte ignored.
// - Colour depth select bit picks deep or shallow word layout.
// - Fill command is followed by words decoded into colour and count.
// - Continue fill command uses the same word layouts.
// - Fill words act only while fill write enable is set.
// - Brightness write command loads the stored brightness.
`timescale 1ns/1ps
`default_nettype none

module bfw_cmd #(
    parameter int ADDR_W = 16,
    parameter int RAM_PIXELS = 65536
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Host port pins
    input wire bfw_pkg::bfw_host_pins_t host_pins,
    output logic [7:0] host_dout,
    output logic host_doe,
    // Controller state
    input wire logic sleep_in,
    input wire logic sw_reset,
    // Backlight
    output logic backlight_en,
    output logic [7:0] backlight_level,
    // Display RAM write port
    output logic ram_we,
    output logic [ADDR_W-1:0] ram_addr,
    output var bfw_pkg::bfw_pixel_t ram_pixel,
    // Status
    output logic fill_busy,
    output logic fill_overrun
);
    import bfw_pkg::*;

    bfw_host_pins_t sync1_r;
    bfw_host_pins_t sync2_r;
    logic wr_n_d_r;
    logic rd_n_d_r;
    bfw_ctx_t ctx_r;
    bfw_ctx_t ctx_nxt;
    logic [1:0] byte_idx_r;
    logic [1:0] byte_idx_nxt;
    logic [1:0] rd_phase_r;
    logic [7:0] brightness_r;
    logic backlight_on_r;
    logic fill_en_r;
    logic c262_r;
    logic cont_mode_r;
    logic first_r;
    logic [31:0] word_r;
    logic [31:0] word_nxt;
    logic pend_valid_r;
    bfw_fill_req_t pend_r;
    logic overrun_r;
    logic [7:0] host_dout_r;
    logic [7:0] level_r;
    logic bl_en_r;

    logic wr_rise;
    logic rd_rise;
    logic cmd_wr;
    logic par_wr;
    logic [7:0] pin_byte;
    logic fill_ctx;
    logic read_ctx;
    logic [1:0] trig_idx;
    logic trig;
    logic taken;
    logic gen_ready;
    logic pend_load;
    bfw_pixel_t pix262;
    bfw_pixel_t pix65;
    bfw_fill_req_t req_nxt;
    logic [7:0] bright_rd;
    logic [7:0] ctrl_rd;
    logic [7:0] rd_val;

    // Two stages before any logic looks at the pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_r <= HOST_IDLE;
            sync2_r <= HOST_IDLE;
            wr_n_d_r <= 1'h1;
            rd_n_d_r <= 1'h1;
        end else if (ce) begin
            sync1_r <= host_pins;
            sync2_r <= sync1_r;
            wr_n_d_r <= sync2_r.wr_n;
            rd_n_d_r <= sync2_r.rd_n;
        end
    end

    assign wr_rise = sync2_r.wr_n & ~wr_n_d_r;
    assign rd_rise = sync2_r.rd_n & ~rd_n_d_r;
    assign cmd_wr = wr_rise & ~sync2_r.dcx;
    assign par_wr = wr_rise & sync2_r.dcx;
    assign pin_byte = sync2_r.data;

    // Unknown codes park the decoder so stray parameters do nothing
    assign ctx_nxt = (pin_byte == CMD_WR_BRIGHT) ? CTX_WR_BRIGHT :
                     (pin_byte == CMD_RD_BRIGHT) ? CTX_RD_BRIGHT :
                     (pin_byte == CMD_WR_CTRL) ? CTX_WR_CTRL :
                     (pin_byte == CMD_RD_CTRL) ? CTX_RD_CTRL :
                     (pin_byte == CMD_FILL) ? CTX_FILL :
                     (pin_byte == CMD_FILL_CONT) ? CTX_FILL :
                     (pin_byte == CMD_FILL_CFG) ? CTX_FILL_CFG :
                     CTX_IDLE;

    assign fill_ctx = (ctx_r == CTX_FILL);
    assign read_ctx = (ctx_r == CTX_RD_BRIGHT) || (ctx_r == CTX_RD_CTRL);
    assign byte_idx_nxt = (fill_ctx || byte_idx_r != LAST_IDX) ? byte_idx_r + 2'h1 : LAST_IDX;

    // Current parameter word with the arriving byte merged in
    always_comb begin
        word_nxt = word_r;
        word_nxt[{byte_idx_r, 3'h0} +: 8] = pin_byte;
    end

    assign pix262.red = word_nxt[R262_LSB +: 6];
    assign pix262.green = word_nxt[G262_LSB +: 6];
    assign pix262.blue = word_nxt[B262_LSB +: 6];
    // Five-bit channels widened by repeating their top bit
    assign pix65.red = {word_nxt[R65_LSB +: 5], word_nxt[R65_LSB + 4]};
    assign pix65.green = {word_nxt[G65_HI_LSB +: 3], word_nxt[G65_LO_LSB +: 3]};
    assign pix65.blue = {word_nxt[B65_LSB +: 5], word_nxt[B65_LSB + 4]};

    assign req_nxt.color = c262_r ? pix262 : pix65;
    assign req_nxt.count_m1 = c262_r ? word_nxt[N262_LSB +: 8] : word_nxt[N65_LSB +: 8];
    assign req_nxt.cont = cont_mode_r | ~first_r;
    assign trig_idx = c262_r ? TRIG_IDX_262 : TRIG_IDX_65;
    assign trig = par_wr & fill_ctx & fill_en_r & (byte_idx_r == trig_idx);

    assign taken = pend_valid_r & gen_ready;
    assign pend_load = trig & (~pend_valid_r | taken);

    assign bright_rd = backlight_on_r ? brightness_r : 8'h00;
    assign ctrl_rd = 8'(backlight_on_r) << BL_POS;
    assign rd_val = (rd_phase_r != PHASE_VALUE) ? DUMMY_BYTE :
                    (ctx_r == CTX_RD_BRIGHT) ? bright_rd :
                    (ctx_r == CTX_RD_CTRL) ? ctrl_rd :
                    DUMMY_BYTE;

    // Decoder context and parameter counters
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctx_r <= CTX_IDLE;
            byte_idx_r <= 2'h0;
            rd_phase_r <= 2'h0;
            cont_mode_r <= 1'h0;
            first_r <= 1'h0;
            word_r <= 32'h0000_0000;
        end else if (ce) begin
            if (sw_reset) begin
                ctx_r <= CTX_IDLE;
                byte_idx_r <= 2'h0;
                rd_phase_r <= 2'h0;
            end else if (cmd_wr) begin
                ctx_r <= ctx_nxt;
                byte_idx_r <= 2'h0;
                rd_phase_r <= 2'h0;
                cont_mode_r <= (pin_byte == CMD_FILL_CONT);
                first_r <= (pin_byte == CMD_FILL);
                word_r <= 32'h0000_0000;
            end else begin
                if (par_wr) begin
                    byte_idx_r <= byte_idx_nxt;
                    word_r <= word_nxt;
                end
                if (trig) begin
                    first_r <= 1'h0;
                end
                if (rd_rise && read_ctx && rd_phase_r != PHASE_DONE) begin
                    rd_phase_r <= rd_phase_r + 2'h1;
                end
            end
        end
    end

    // Software visible settings
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            brightness_r <= BRIGHT_RST;
            backlight_on_r <= BL_RST;
            fill_en_r <= 1'h0;
            c262_r <= 1'h0;
        end else if (ce) begin
            if (sw_reset) begin
                brightness_r <= BRIGHT_RST;
                backlight_on_r <= BL_RST;
            end else begin
                if (sleep_in) begin
                    brightness_r <= BRIGHT_RST;
                end else if (par_wr && ctx_r == CTX_WR_BRIGHT && byte_idx_r == 2'h0) begin
                    brightness_r <= pin_byte;
                end
                if (par_wr && ctx_r == CTX_WR_CTRL && byte_idx_r == 2'h0) begin
                    backlight_on_r <= pin_byte[BL_POS];
                end
                if (par_wr && ctx_r == CTX_FILL_CFG && byte_idx_r == 2'h0) begin
                    fill_en_r <= pin_byte[CFG_EN_POS];
                    c262_r <= pin_byte[CFG_C262_POS];
                end
            end
        end
    end

    // One word waits here while the engine is busy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_valid_r <= 1'h0;
            pend_r <= '0;
            overrun_r <= 1'h0;
        end else if (ce) begin
            if (pend_load) begin
                pend_valid_r <= 1'h1;
                pend_r <= req_nxt;
            end else if (taken) begin
                pend_valid_r <= 1'h0;
            end
            // A new overrun wins over a software reset in the same cycle
            overrun_r <= (trig & ~pend_load) | (overrun_r & ~sw_reset);
        end
    end

    // Outputs from flops; backlight lines low whenever it is off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_dout_r <= DUMMY_BYTE;
            level_r <= 8'h00;
            bl_en_r <= 1'h0;
        end else if (ce) begin
            host_dout_r <= rd_val;
            level_r <= bright_rd;
            bl_en_r <= backlight_on_r;
        end
    end

    bfw_fill_gen #(
        .ADDR_W(ADDR_W),
        .RAM_PIXELS(RAM_PIXELS)
    ) u_fill (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .req_valid(pend_valid_r),
        .req_ready(gen_ready),
        .req(pend_r),
        .pix_we(ram_we),
        .pix_addr(ram_addr),
        .pix_data(ram_pixel)
    );

    assign host_dout = host_dout_r;
    assign host_doe = read_ctx & ~sync2_r.rd_n;
    assign backlight_en = bl_en_r;
    assign backlight_level = level_r;
    assign fill_busy = pend_valid_r | ~gen_ready;
    assign fill_overrun = overrun_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_sleep_clear;
        (ce && sleep_in && !sw_reset) |=> (brightness_r == 8'h00);
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("brightness kept in sleep");

    property p_dummy_first;
        (ce && cmd_wr && !sw_reset && pin_byte == CMD_RD_BRIGHT) ##1 ce |=> (host_dout == DUMMY_BYTE);
    endproperty
    a_dummy_first: assert property (p_dummy_first) else $error("no dummy byte first");

    property p_bright_zero;
        (ce && ctx_r == CTX_RD_BRIGHT && rd_phase_r == PHASE_VALUE && !backlight_on_r) |=> (host_dout == 8'h00);
    endproperty
    a_bright_zero: assert property (p_bright_zero) else $error("brightness read not zero");

    property p_bright_value;
        (ce && ctx_r == CTX_RD_BRIGHT && rd_phase_r == PHASE_VALUE && backlight_on_r)
            |=> (host_dout == $past(brightness_r));
    endproperty
    a_bright_value: assert property (p_bright_value) else $error("brightness read wrong");

    property p_bl_write;
        (ce && !sw_reset && par_wr && ctx_r == CTX_WR_CTRL && byte_idx_r == 2'h0)
            |=> (backlight_on_r == $past(pin_byte[BL_POS])) ##1 (!ce || backlight_en == backlight_on_r);
    endproperty
    a_bl_write: assert property (p_bl_write) else $error("backlight bit not taken");

    property p_bl_off;
        (ce && !backlight_on_r) |=> (backlight_level == 8'h00 && !backlight_en);
    endproperty
    a_bl_off: assert property (p_bl_off) else $error("backlight lines not low");

    property p_ctrl_read;
        (ce && ctx_r == CTX_RD_CTRL && rd_phase_r == PHASE_VALUE) |=> (host_dout == {5'h00, $past(backlight_on_r), 2'h0});
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_count_262;
        (ce && trig && !pend_valid_r && c262_r) |=> (pend_valid_r && pend_r.count_m1 == $past(pin_byte));
    endproperty
    a_count_262: assert property (p_count_262) else $error("deep count wrong");

    property p_count_65;
        (ce && trig && !pend_valid_r && !c262_r) |=> (pend_r.count_m1 == $past(pin_byte) && $past(byte_idx_r) == 2'h2);
    endproperty
    a_count_65: assert property (p_count_65) else $error("shallow count wrong");

    property p_fill_disabled;
        (ce && !fill_en_r && !pend_valid_r) |=> !pend_valid_r;
    endproperty
    a_fill_disabled: assert property (p_fill_disabled) else $error("fill while disabled");

    property p_sw_reset;
        (ce && sw_reset) |=> (brightness_r == 8'h00 && !backlight_on_r);
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("soft reset left settings");

    c_bright_read: cover property (ce && ctx_r == CTX_RD_BRIGHT && rd_phase_r == PHASE_VALUE && backlight_on_r);
    c_fill_262: cover property (ce && trig && c262_r);
    c_fill_cont: cover property (ce && trig && cont_mode_r);
    c_overrun: cover property (ce && trig && !pend_load);

endmodule : bfw_cmd

`default_nettype wire

/* bfw_fill_gen.sv */
/*
 * Pixel fill engine: writes one colour into N consecutive RAM pixels.
 * Assumes requests come from the command decoder on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bfw_fill_gen #(
    parameter int ADDR_W = 16,
    parameter int RAM_PIXELS = 65536
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Fill request
    input wire logic req_valid,
    output logic req_ready,
    input wire bfw_pkg::bfw_fill_req_t req,
    // RAM write port
    output logic pix_we,
    output logic [ADDR_W-1:0] pix_addr,
    output var bfw_pkg::bfw_pixel_t pix_data
);
    import bfw_pkg::*;

    if (RAM_PIXELS < 2 || RAM_PIXELS > 2 ** ADDR_W) begin : g_bad_size
        $error("RAM_PIXELS does not fit ADDR_W");
    end

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(RAM_PIXELS - 1);

    logic active_r;
    logic [7:0] left_r;
    bfw_pixel_t color_r;
    logic [ADDR_W-1:0] addr_r;
    logic pix_we_r;
    logic [ADDR_W-1:0] pix_addr_r;
    bfw_pixel_t pix_data_r;
    logic take;
    logic [ADDR_W-1:0] addr_step;

    assign req_ready = ~active_r;
    assign take = req_valid & ~active_r;
    // Wraps so a long stream never leaves the array
    assign addr_step = (addr_r == LAST_ADDR) ? '0 : addr_r + 1'b1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_r <= 1'h0;
            left_r <= 8'h00;
            color_r <= '0;
            addr_r <= '0;
            pix_we_r <= 1'h0;
            pix_addr_r <= '0;
            pix_data_r <= '0;
        end else if (ce) begin
            pix_we_r <= active_r;
            if (active_r) begin
                pix_addr_r <= addr_r;
                pix_data_r <= color_r;
                addr_r <= addr_step;
                left_r <= left_r - 8'h01;
                active_r <= (left_r != 8'h00);
            end else if (take) begin
                active_r <= 1'h1;
                left_r <= req.count_m1;
                color_r <= req.color;
                if (!req.cont) begin
                    addr_r <= '0;
                end
            end
        end
    end

    assign pix_we = pix_we_r;
    assign pix_addr = pix_addr_r;
    assign pix_data = pix_data_r;

    property p_origin;
        @(posedge clk) disable iff (!rst_n)
        (ce && take && !req.cont) |=> (addr_r == '0);
    endproperty
    a_origin: assert property (p_origin) else $error("fill did not restart at origin");

    property p_single_pixel;
        @(posedge clk) disable iff (!rst_n)
        (ce && take && req.count_m1 == 8'h00) ##1 ce |=> !active_r ##0 pix_we;
    endproperty
    a_single_pixel: assert property (p_single_pixel) else $error("count one wrote wrong length");

endmodule : bfw_fill_gen

`default_nettype wire

/* bfw_host_model.sv */
/*
 * Host processor model for the brightness and fill command port.
 * Assumes a clk of the device's rate; drives pins after falling edges and
 * keeps write strobe levels and data hold at four clocks; read strobe low six clocks, then high five.
 */
`timescale 1ns/1ps
`default_nettype none

module bfw_host_model (
    // Clock
    input wire logic clk,
    // Device pins
    output var bfw_pkg::bfw_host_pins_t pins,
    input wire logic [7:0] dout,
    input wire logic doe
);
    import bfw_pkg::*;

    initial pins = HOST_IDLE;

    task automatic put_byte(input logic dcx, input logic [7:0] val);
        @(negedge clk);
        pins.dcx = dcx;
        pins.data = val;
        repeat (4) @(negedge clk);
        pins.wr_n = 1'b0;
        repeat (4) @(negedge clk);
        pins.wr_n = 1'b1;
        repeat (4) @(negedge clk);
        // Released bus must not keep the last value
        pins.data = ~val;
    endtask : put_byte

    // Words go low byte first, four bytes whatever the depth
    task automatic put_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            put_byte(1'b1, w[8*i +: 8]);
        end
    endtask : put_word

    task automatic get_byte(output logic [7:0] val, output logic oe);
        @(negedge clk);
        pins.dcx = 1'b1;
        pins.rd_n = 1'b0;
        repeat (6) @(negedge clk);
        val = dout;
        oe = doe;
        pins.rd_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask : get_byte

endmodule : bfw_host_model

`default_nettype wire

/* bfw_pkg.sv */
/*
 * Shared constants and types for the brightness and fill command block.
 * Assumes an 8-bit host port; parameter words are gathered low byte first.
 */
`default_nettype none

package bfw_pkg;

    // Command codes
    localparam logic [7:0] CMD_WR_BRIGHT = 8'h51;
    localparam logic [7:0] CMD_RD_BRIGHT = 8'h52;
    localparam logic [7:0] CMD_WR_CTRL = 8'h53;
    localparam logic [7:0] CMD_RD_CTRL = 8'h54;
    localparam logic [7:0] CMD_FILL = 8'h6C;
    localparam logic [7:0] CMD_FILL_CONT = 8'h6D;
    localparam logic [7:0] CMD_FILL_CFG = 8'h6F;

    // Parameter bit positions
    localparam int BL_POS = 2;
    localparam int CFG_EN_POS = 4;
    localparam int CFG_C262_POS = 7;

    // Fill word field positions
    localparam int R262_LSB = 2;
    localparam int G262_LSB = 10;
    localparam int B262_LSB = 18;
    localparam int N262_LSB = 24;
    localparam int R65_LSB = 3;
    localparam int G65_HI_LSB = 0;
    localparam int G65_LO_LSB = 13;
    localparam int B65_LSB = 8;
    localparam int N65_LSB = 16;

    // Byte index that completes a word, and the index counting stops at outside a fill
    localparam logic [1:0] TRIG_IDX_262 = 2'h3;
    localparam logic [1:0] TRIG_IDX_65 = 2'h2;
    localparam logic [1:0] LAST_IDX = 2'h3;

    // Values after reset, and read phase codes
    localparam logic [7:0] BRIGHT_RST = 8'h00;
    localparam logic BL_RST = 1'h0;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam logic [1:0] PHASE_VALUE = 2'h1;
    localparam logic [1:0] PHASE_DONE = 2'h2;

    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } bfw_pixel_t;

    typedef struct packed {
        bfw_pixel_t color;
        logic [7:0] count_m1;
        logic cont;
    } bfw_fill_req_t;

    typedef struct packed {
        logic dcx;
        logic wr_n;
        logic rd_n;
        logic [7:0] data;
    } bfw_host_pins_t;

    localparam bfw_host_pins_t HOST_IDLE = '{dcx: 1'h0, wr_n: 1'h1, rd_n: 1'h1, data: 8'h00};

    typedef enum logic [2:0] {
        CTX_IDLE = 3'b000,
        CTX_WR_BRIGHT = 3'b001,
        CTX_RD_BRIGHT = 3'b010,
        CTX_WR_CTRL = 3'b011,
        CTX_RD_CTRL = 3'b100,
        CTX_FILL = 3'b101,
        CTX_FILL_CFG = 3'b110
    } bfw_ctx_t;

endpackage : bfw_pkg

`default_nettype wire

/* tb_top.sv */
/*
 * Self-checking bench for the brightness and fill command decoder.
 * Assumes the host model above and a small RAM of 16 pixels.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bfw_pkg::*;
    localparam int AW = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic sleep_in = 1'b0;
    logic sw_reset = 1'b0;
    bfw_host_pins_t host_pins;
    logic [7:0] host_dout;
    logic host_doe;
    logic backlight_en;
    logic [7:0] backlight_level;
    logic ram_we;
    logic [AW-1:0] ram_addr;
    bfw_pixel_t ram_pixel;
    logic fill_busy;
    logic fill_overrun;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [AW-1:0] addr_q[$];
    bfw_pixel_t pix_q[$];

    always #20 clk = ~clk;

    bfw_host_model bfw_host_model_inst (.clk(clk), .pins(host_pins), .dout(host_dout), .doe(host_doe));

    bfw_cmd #(.ADDR_W(AW), .RAM_PIXELS(16)) bfw_cmd_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .host_pins(host_pins), .host_dout(host_dout),
        .host_doe(host_doe), .sleep_in(sleep_in), .sw_reset(sw_reset),
        .backlight_en(backlight_en), .backlight_level(backlight_level), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_pixel(ram_pixel), .fill_busy(fill_busy), .fill_overrun(fill_overrun)
    );

    // Sampled mid-cycle, where each one-cycle pulse stands settled
    always @(negedge clk) begin
        if (ram_we === 1'b1) begin
            addr_q.push_back(ram_addr);
            pix_q.push_back(ram_pixel);
        end
    end

    // Ceiling far above the roughly 1800 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("Error at %0t: run timed out", $time);
            results();
        end
    end

    task automatic results();
        $display("Checks: %0d, mismatches: %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pix(input bfw_pixel_t got, input bfw_pixel_t exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: pixel %h expected %h", $time, got, exp);
        end
    endtask : chk_pix

    task automatic wr_cmd(input logic [7:0] cmd, input logic [7:0] par);
        bfw_host_model_inst.put_byte(1'b0, cmd);
        bfw_host_model_inst.put_byte(1'b1, par);
        repeat (2) @(negedge clk);
    endtask : wr_cmd

    // Dummy byte first, then the value
    task automatic rd_cmd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        bfw_host_model_inst.put_byte(1'b0, cmd);
        bfw_host_model_inst.get_byte(d, oe);
        chk({23'h0, oe, d}, {23'h0, 1'b1, DUMMY_BYTE});
        bfw_host_model_inst.get_byte(d, oe);
        chk({23'h0, oe, d}, {23'h0, 1'b1, exp});
    endtask : rd_cmd

    task automatic fill(input logic [7:0] cmd, input logic [31:0] w);
        int k;
        bfw_host_model_inst.put_byte(1'b0, cmd);
        bfw_host_model_inst.put_word(w);
        repeat (4) @(negedge clk);
        for (k = 0; k < 400 && fill_busy !== 1'b0; k++) begin
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
    endtask : fill

    task automatic chk_fill(input logic [AW-1:0] a0, input int n, input bfw_pixel_t p);
        chk(addr_q.size(), n);
        for (int i = 0; i < addr_q.size() && i < n; i++) begin
            chk({28'h0, addr_q[i]}, {28'h0, a0 + AW'(i)});
            chk_pix(pix_q[i], p);
        end
        addr_q.delete();
        pix_q.delete();
    endtask : chk_fill

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({28'h0, host_doe, backlight_en, fill_busy, fill_overrun}, 32'h0000_0000);
        rd_cmd(CMD_RD_BRIGHT, 8'h00);
        rd_cmd(CMD_RD_CTRL, 8'h00);
        $display("test reset done");
        wr_cmd(CMD_WR_BRIGHT, 8'hAA);
        rd_cmd(CMD_RD_BRIGHT, 8'h00);
        wr_cmd(CMD_WR_CTRL, 8'h04);
        chk({23'h0, backlight_en, backlight_level}, 32'h0000_01AA);
        rd_cmd(CMD_RD_CTRL, 8'h04);
        rd_cmd(CMD_RD_BRIGHT, 8'hAA);
        wr_cmd(CMD_WR_BRIGHT, 8'hFF);
        rd_cmd(CMD_RD_BRIGHT, 8'hFF);
        // Every bit but the backlight bit set: must read as off
        wr_cmd(CMD_WR_CTRL, 8'hFB);
        chk({23'h0, backlight_en, backlight_level}, 32'h0000_0000);
        rd_cmd(CMD_RD_CTRL, 8'h00);
        $display("test brightness done");
        wr_cmd(CMD_WR_CTRL, 8'h04);
        sleep_in = 1'b1;
        repeat (3) @(negedge clk);
        sleep_in = 1'b0;
        rd_cmd(CMD_RD_BRIGHT, 8'h00);
        wr_cmd(CMD_WR_BRIGHT, 8'h55);
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        repeat (2) @(negedge clk);
        chk({23'h0, backlight_en, backlight_level}, 32'h0000_0000);
        rd_cmd(CMD_RD_CTRL, 8'h00);
        // Backlight back on so a surviving brightness would show
        wr_cmd(CMD_WR_CTRL, 8'h04);
        rd_cmd(CMD_RD_BRIGHT, 8'h00);
        // A write while the enable is low must leave no trace
        ce = 1'b0;
        wr_cmd(CMD_WR_BRIGHT, 8'h12);
        ce = 1'b1;
        rd_cmd(CMD_RD_BRIGHT, 8'h00);
        $display("test sleep and soft reset done");
        wr_cmd(CMD_FILL_CFG, 8'h90);
        fill(CMD_FILL, 32'h02CC_54A8);
        chk_fill(4'h0, 3, '{red: 6'h2A, green: 6'h15, blue: 6'h33});
        fill(CMD_FILL_CONT, 32'h0104_00FC);
        chk_fill(4'h3, 2, '{red: 6'h3F, green: 6'h00, blue: 6'h01});
        $display("test deep fill done");
        wr_cmd(CMD_FILL_CFG, 8'h10);
        fill(CMD_FILL, 32'hEE00_60FD);
        chk_fill(4'h0, 1, '{red: 6'h3F, green: 6'h2B, blue: 6'h00});
        wr_cmd(CMD_FILL_CFG, 8'h00);
        fill(CMD_FILL, 32'h0300_60FD);
        chk_fill(4'h0, 0, '{red: 6'h00, green: 6'h00, blue: 6'h00});
        $display("test shallow fill done");
        // Three full-length words: one runs, one waits, the third is dropped
        wr_cmd(CMD_FILL_CFG, 8'h90);
        bfw_host_model_inst.put_byte(1'b0, CMD_FILL);
        repeat (3) bfw_host_model_inst.put_word(32'hFFFC_FCFC);
        chk({30'h0, fill_busy, fill_overrun}, 32'h0000_0003);
        repeat (600) @(negedge clk);
        chk({30'h0, fill_busy, fill_overrun}, 32'h0000_0001);
        chk_fill(4'h0, 512, '{red: 6'h3F, green: 6'h3F, blue: 6'h3F});
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        @(negedge clk);
        chk({31'h0, fill_overrun}, 32'h0000_0000);
        $display("test overrun done");
        results();
    end

endmodule : tb_top

`default_nettype wire
